/* viu_pkg.sv */
// Purpose: Shared constants for the vectored interrupt unit
// Assumes: One clock domain, channel map fixed at build time
// Notes: Channels above the last mapped source stay inactive
`default_nettype none
package viu_pkg;
  localparam int NUM_CHANNELS = 32;
  localparam int NUM_SLOTS = 16;
  localparam int CHAN_W = 5;
  localparam int SLOT_W = 4;
  localparam int ADDR_W = 32;

  // Channel numbers of the fixed source map
  localparam int CH_WATCHDOG = 0;
  localparam int CH_SOFTWARE = 1;
  localparam int CH_DEBUG_RX = 2;
  localparam int CH_DEBUG_TX = 3;
  localparam int CH_TIMER0 = 4;
  localparam int CH_TIMER1 = 5;
  localparam int CH_UART0 = 6;
  localparam int CH_UART1 = 7;
  localparam int CH_PWM = 8;
  localparam int CH_I2C0 = 9;
  localparam int CH_SPI = 10;
  localparam int CH_SSP = 11;
  localparam int CH_PLL = 12;
  localparam int CH_RTC = 13;
  localparam int CH_EXT_PIN0 = 14;
  localparam int CH_ADC0 = 18;
  localparam int CH_I2C1 = 19;
  localparam int CH_BROWNOUT = 20;
  localparam int CH_ADC1 = 21;

  // Source flag counts
  localparam int TIMER_MATCHES = 4;
  localparam int TIMER_CAPTURES = 4;
  localparam int PWM_MATCHES = 7;
  localparam int PWM_CAPTURES = 4;
  localparam int EXT_PINS = 4;

  // Channels with a connected source; the rest read as zero
  localparam logic [31:0] USED_CHANNELS = 32'h003f_ffff;

  // Reset values
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] ADDRESS_RESET = 32'h0000_0000;
endpackage : viu_pkg
`default_nettype wire

/* viu_vector_mem.sv */
// Purpose: Handler address store, one word per vectored slot
// Assumes: Single write port, single registered read port
// Notes: Read data appear one edge after the read enable
`timescale 1ns/1ps
`default_nettype none
module viu_vector_mem (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Write port
  input wire logic wr_en,
  input wire logic [viu_pkg::SLOT_W-1:0] wr_slot,
  input wire logic [viu_pkg::ADDR_W-1:0] wr_data,
  // Read port
  input wire logic rd_en,
  input wire logic [viu_pkg::SLOT_W-1:0] rd_slot,
  output logic [viu_pkg::ADDR_W-1:0] rd_data
);
  import viu_pkg::*;

  typedef struct packed {
    logic [NUM_SLOTS-1:0][ADDR_W-1:0] words;
    logic [ADDR_W-1:0] rd_data;
  } viu_mem_state_type;

  viu_mem_state_type mem_q;
  viu_mem_state_type mem_d;

  always_comb begin
    mem_d = mem_q;
    if (wr_en) begin
      mem_d.words[wr_slot] = wr_data;
    end
    if (rd_en) begin
      mem_d.rd_data = mem_q.words[rd_slot];
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mem_q <= '0;
    end else begin
      mem_q <= mem_d;
    end
  end

  assign rd_data = mem_q.rd_data;
endmodule // viu_vector_mem
`default_nettype wire

/* viu_slot_picker.sv */
// Purpose: Pick the lowest-numbered active vectored slot
// Assumes: Slot 0 wins over every other slot
// Notes: Purely combinational
`timescale 1ns/1ps
`default_nettype none
module viu_slot_picker (
  // Slot requests
  input wire logic [viu_pkg::NUM_SLOTS-1:0] slot_hit,
  // Winner
  output logic found,
  output logic [viu_pkg::SLOT_W-1:0] winner
);
  import viu_pkg::*;

  always_comb begin
    found = 1'b0;
    winner = '0;
    // Scan downward so the lowest slot is left standing
    for (int s = NUM_SLOTS - 1; s >= 0; s--) begin
      if (slot_hit[s]) begin
        found = 1'b1;
        winner = SLOT_W'(s);
      end
    end
  end
endmodule // viu_slot_picker
`default_nettype wire

/* viu_vectored_irq_unit.sv */
// Purpose: Vectored interrupt unit gathering peripheral requests
// Assumes: Peripheral flags come from logic on clock; pins do not
// Notes: Raw status lags same-clock sources one edge, class outputs two
// Notes: Pin channels add two synchroniser edges on top
// Notes: A handler read is answered two edges after it is taken
`timescale 1ns/1ps
`default_nettype none
module viu_vectored_irq_unit (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Single-line sources
  input wire logic watchdog_flag,
  input wire logic soft_request,
  input wire logic debug_rx_request,
  input wire logic debug_tx_request,
  input wire logic i2c0_request,
  input wire logic spi_request,
  input wire logic pll_lock_request,
  input wire logic adc0_request,
  input wire logic i2c1_request,
  input wire logic brownout_request,
  input wire logic adc1_request,
  // Timer flags
  input wire logic [viu_pkg::TIMER_MATCHES-1:0] timer0_match_flag,
  input wire logic [viu_pkg::TIMER_CAPTURES-1:0] timer0_capture_flag,
  input wire logic [viu_pkg::TIMER_MATCHES-1:0] timer1_match_flag,
  input wire logic [viu_pkg::TIMER_CAPTURES-1:0] timer1_capture_flag,
  // First serial port flags
  input wire logic uart0_rx_line_status_flag,
  input wire logic uart0_tx_holding_empty_flag,
  input wire logic uart0_rx_data_avail_flag,
  input wire logic uart0_char_timeout_flag,
  // Second serial port flags
  input wire logic uart1_rx_line_status_flag,
  input wire logic uart1_tx_holding_empty_flag,
  input wire logic uart1_rx_data_avail_flag,
  input wire logic uart1_char_timeout_flag,
  input wire logic uart1_modem_status_flag,
  // Pulse-width unit flags
  input wire logic [viu_pkg::PWM_MATCHES-1:0] pwm_match_flag,
  input wire logic [viu_pkg::PWM_CAPTURES-1:0] pwm_capture_flag,
  // Synchronous serial port flags
  input wire logic ssp_tx_half_empty_flag,
  input wire logic ssp_rx_half_full_flag,
  input wire logic ssp_rx_timeout_flag,
  input wire logic ssp_rx_overrun_flag,
  // Real-time clock flags
  input wire logic rtc_counter_increment_flag,
  input wire logic rtc_alarm_flag,
  // External pins, asynchronous
  input wire logic [viu_pkg::EXT_PINS-1:0] ext_pin_request,
  // Class settings
  input wire logic [viu_pkg::NUM_CHANNELS-1:0] channel_enable,
  input wire logic [viu_pkg::NUM_CHANNELS-1:0] fast_select,
  input wire logic [viu_pkg::NUM_SLOTS-1:0] slot_enable,
  input wire logic [viu_pkg::NUM_SLOTS*viu_pkg::CHAN_W-1:0] slot_channel,
  input wire logic [viu_pkg::ADDR_W-1:0] default_address,
  // Slot address write port
  input wire logic slot_addr_wr_en,
  input wire logic [viu_pkg::SLOT_W-1:0] slot_addr_wr_slot,
  input wire logic [viu_pkg::ADDR_W-1:0] slot_addr_wr_data,
  // Handler address read
  input wire logic handler_read,
  output logic [viu_pkg::ADDR_W-1:0] handler_address,
  output logic handler_valid,
  // Requests to the core
  output logic fast_request_out,
  output logic normal_request_out,
  // Status words
  output logic [viu_pkg::NUM_CHANNELS-1:0] raw_status,
  output logic [viu_pkg::NUM_CHANNELS-1:0] fast_status,
  output logic [viu_pkg::NUM_CHANNELS-1:0] normal_status,
  output logic [viu_pkg::NUM_CHANNELS-1:0] nonvectored_status
);
  import viu_pkg::*;

  typedef struct packed {
    logic [EXT_PINS-1:0] pin_meta;
    logic [EXT_PINS-1:0] pin_sync;
    logic [NUM_CHANNELS-1:0] raw;
    logic [NUM_CHANNELS-1:0] fast_stat;
    logic [NUM_CHANNELS-1:0] norm_stat;
    logic [NUM_CHANNELS-1:0] nonvec_stat;
    logic fast_req;
    logic norm_req;
    logic rd_pend;
    logic rd_hit;
    logic [ADDR_W-1:0] handler;
    logic handler_valid;
  } viu_state_type;

  viu_state_type q;
  viu_state_type d;

  logic [NUM_CHANNELS-1:0] src;
  logic [NUM_SLOTS-1:0] slot_hit;
  logic [NUM_CHANNELS-1:0] slot_claim [NUM_SLOTS];
  logic [NUM_CHANNELS-1:0] claimed;
  logic win_found;
  logic [SLOT_W-1:0] win_slot;
  logic [ADDR_W-1:0] mem_rd_data;
  logic timer0_line;
  logic timer1_line;
  logic uart0_line;
  logic uart1_line;
  logic pwm_line;
  logic ssp_line;
  logic rtc_line;
  logic [NUM_CHANNELS-1:0] fast_hit;
  logic [NUM_CHANNELS-1:0] norm_hit;
  logic [NUM_CHANNELS-1:0] nonvec_hit;
  logic [ADDR_W-1:0] answer;

  ////////////////////////////////////////////////////////////////////////
  // Peripheral lines, each the OR of all flags of one block
  assign timer0_line = (|timer0_match_flag)
                     | (|timer0_capture_flag);
  assign timer1_line = (|timer1_match_flag)
                     | (|timer1_capture_flag);
  assign uart0_line = uart0_rx_line_status_flag
                    | uart0_tx_holding_empty_flag
                    | uart0_rx_data_avail_flag
                    | uart0_char_timeout_flag;
  // Only the second port carries modem status
  assign uart1_line = uart1_rx_line_status_flag
                    | uart1_tx_holding_empty_flag
                    | uart1_rx_data_avail_flag
                    | uart1_char_timeout_flag
                    | uart1_modem_status_flag;
  assign pwm_line = (|pwm_match_flag)
                  | (|pwm_capture_flag);
  assign ssp_line = ssp_tx_half_empty_flag
                  | ssp_rx_half_full_flag
                  | ssp_rx_timeout_flag
                  | ssp_rx_overrun_flag;
  assign rtc_line = rtc_counter_increment_flag
                  | rtc_alarm_flag;

  ////////////////////////////////////////////////////////////////////////
  // Source map
  always_comb begin
    src = '0;
    src[CH_WATCHDOG] = watchdog_flag;
    src[CH_SOFTWARE] = soft_request;
    src[CH_DEBUG_RX] = debug_rx_request;
    src[CH_DEBUG_TX] = debug_tx_request;
    // Flag groups arrive already merged per block
    src[CH_TIMER0] = timer0_line;
    src[CH_TIMER1] = timer1_line;
    src[CH_UART0] = uart0_line;
    src[CH_UART1] = uart1_line;
    src[CH_PWM] = pwm_line;
    src[CH_I2C0] = i2c0_request;
    src[CH_SPI] = spi_request;
    src[CH_SSP] = ssp_line;
    src[CH_PLL] = pll_lock_request;
    src[CH_RTC] = rtc_line;
    src[CH_EXT_PIN0 +: EXT_PINS] = q.pin_sync;
    src[CH_ADC0] = adc0_request;
    src[CH_I2C1] = i2c1_request;
    src[CH_BROWNOUT] = brownout_request;
    src[CH_ADC1] = adc1_request;
  end

  ////////////////////////////////////////////////////////////////////////
  // Vectored slots
  genvar gs;
  for (gs = 0; gs < NUM_SLOTS; gs++) begin : g_slot
    logic [CHAN_W-1:0] ch;
    assign ch = slot_channel[gs*CHAN_W +: CHAN_W];
    // Normal-class only, so fast sources never win a slot
    assign slot_hit[gs] = slot_enable[gs] & q.norm_stat[ch];
    assign slot_claim[gs] = slot_enable[gs]
                          ? (32'h0000_0001 << ch)
                          : 32'h0000_0000;
  end

  always_comb begin
    claimed = '0;
    // Channels held by any enabled slot
    for (int s = 0; s < NUM_SLOTS; s++) begin
      claimed = claimed | slot_claim[s];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-channel class sort
  genvar gc;
  for (gc = 0; gc < NUM_CHANNELS; gc++) begin : g_chan
    logic live;
    // Disabled or unmapped channels reach no class
    assign live = q.raw[gc] & channel_enable[gc];
    assign fast_hit[gc] = live & fast_select[gc];
    assign norm_hit[gc] = live & ~fast_select[gc];
    // A slot-claimed channel leaves the default group
    assign nonvec_hit[gc] = norm_hit[gc] & ~claimed[gc];
  end

  // No vectored hit falls back to the shared default
  assign answer = q.rd_hit
                ? mem_rd_data
                : default_address;

  ////////////////////////////////////////////////////////////////////////
  // Winner pick and handler address store
  viu_slot_picker u_picker (
    .slot_hit(slot_hit),
    .found(win_found),
    .winner(win_slot)
  );

  viu_vector_mem u_mem (
    .clock(clock),
    .rst_b(rst_b),
    .wr_en(slot_addr_wr_en),
    .wr_slot(slot_addr_wr_slot),
    .wr_data(slot_addr_wr_data),
    .rd_en(handler_read),
    .rd_slot(win_slot),
    .rd_data(mem_rd_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    d = q;
    // Pins pass two flip-flops before use
    d.pin_meta = ext_pin_request;
    d.pin_sync = q.pin_meta;
    // Status words and merged requests
    d.raw = src & USED_CHANNELS;
    d.fast_stat = fast_hit;
    d.norm_stat = norm_hit;
    d.nonvec_stat = nonvec_hit;
    d.fast_req = |fast_hit;
    d.norm_req = |norm_hit;
    // Winner is picked at the read edge, answered one edge later
    d.handler_valid = 1'b0;
    d.rd_pend = handler_read;
    if (handler_read) begin
      d.rd_hit = win_found;
    end
    if (q.rd_pend) begin
      d.handler = answer;
      d.handler_valid = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      q <= '{
        pin_meta: '0,
        pin_sync: '0,
        raw: STATUS_RESET,
        fast_stat: STATUS_RESET,
        norm_stat: STATUS_RESET,
        nonvec_stat: STATUS_RESET,
        fast_req: 1'b0,
        norm_req: 1'b0,
        rd_pend: 1'b0,
        rd_hit: 1'b0,
        handler: ADDRESS_RESET,
        handler_valid: 1'b0
      };
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  // Every output is read straight from a register
  assign fast_request_out = q.fast_req;
  assign normal_request_out = q.norm_req;
  assign raw_status = q.raw;
  assign fast_status = q.fast_stat;
  assign normal_status = q.norm_stat;
  assign nonvectored_status = q.nonvec_stat;
  assign handler_address = q.handler;
  assign handler_valid = q.handler_valid;
endmodule // viu_vectored_irq_unit
`default_nettype wire

/* viu_checker.sv */
// Purpose: Port checks for the vectored interrupt unit
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
module viu_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Sources and settings
  input wire logic [viu_pkg::TIMER_MATCHES-1:0] timer0_match_flag,
  input wire logic [viu_pkg::EXT_PINS-1:0] ext_pin_request,
  input wire logic [viu_pkg::NUM_CHANNELS-1:0] channel_enable,
  input wire logic [viu_pkg::NUM_CHANNELS-1:0] fast_select,
  // Handler read and outputs
  input wire logic handler_read,
  input wire logic handler_valid,
  input wire logic fast_request_out,
  input wire logic normal_request_out,
  input wire logic [viu_pkg::NUM_CHANNELS-1:0] raw_status,
  input wire logic [viu_pkg::NUM_CHANNELS-1:0] fast_status,
  input wire logic [viu_pkg::NUM_CHANNELS-1:0] normal_status,
  input wire logic [viu_pkg::NUM_CHANNELS-1:0] nonvectored_status
);
  import viu_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_answer;
    ##2 handler_valid;
  endsequence
  a_fast_merge: assert property (fast_request_out == (|fast_status))
    else $error("fast request differs from fast status");
  a_normal_merge: assert property (normal_request_out == (|normal_status))
    else $error("normal request differs from normal status");
  a_unused_quiet: assert property (((raw_status | fast_status | normal_status) >> 22) == 0)
    else $error("unmapped channel active");
  a_class_split: assert property ((fast_status & normal_status) == 0)
    else $error("channel in two classes");
  a_nonvec_subset: assert property ((nonvectored_status & ~normal_status) == 0)
    else $error("non-vectored bit outside normal status");
  a_fast_cause: assert property ($past(rst_b) |->
    fast_status == $past(raw_status & channel_enable & fast_select))
    else $error("fast status wrong");
  a_normal_cause: assert property ($past(rst_b) |->
    normal_status == $past(raw_status & channel_enable & ~fast_select))
    else $error("normal status wrong");
  a_timer_line: assert property ($past(rst_b) && $past(|timer0_match_flag) |-> raw_status[4])
    else $error("timer line not raised");
  a_pin_order: assert property ($past(rst_b) && $past(rst_b, 2) && $past(rst_b, 3) |->
    raw_status[17:14] == $past(ext_pin_request, 3))
    else $error("pin channels wrong");
  a_read_answer: assert property (handler_read |-> s_answer)
    else $error("read not answered");
  a_answer_cause: assert property (handler_valid |-> $past(handler_read, 2))
    else $error("answer without read");
endmodule // viu_checker
`default_nettype wire

/* viu_core_model.sv */
// Purpose: Core side model issuing handler reads
// Assumes: One read per start pulse
// Notes: Captures the answer on the valid pulse
`timescale 1ns/1ps
`default_nettype none
module viu_core_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Bench control
  input wire logic start,
  output logic done,
  output logic [viu_pkg::ADDR_W-1:0] vector,
  // Unit side
  input wire logic handler_valid,
  input wire logic [viu_pkg::ADDR_W-1:0] handler_address,
  output logic handler_read
);
  import viu_pkg::*;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      handler_read <= 1'b0;
      done <= 1'b0;
      vector <= '0;
    end else begin
      handler_read <= start;
      done <= handler_valid;
      if (handler_valid) vector <= handler_address;
    end
  end
endmodule // viu_core_model
`default_nettype wire

/* test_viu_vectored_irq_unit.sv */
// Purpose: Self-checking bench for the vectored interrupt unit
// Assumes: Core model issues handler reads
// Notes: Pins need three edges to reach raw status, four for class status
`timescale 1ns/1ps
`default_nettype none
module test_viu_vectored_irq_unit;
  import viu_pkg::*;
  // First flag bit of each channel
  localparam int BND[23] = '{0, 1, 2, 3, 4, 12, 20, 24, 29, 40, 41, 42, 46, 47, 49, 50, 51, 52,
    53, 54, 55, 56, 57};
  logic clock, rst_b, start, wr_en, done, hread, hvalid, freq, nreq;
  logic [56:0] fl, v;
  logic [31:0] en, fs, dflt, wr_data, vec, hadr, raw, fst, nst, nvs;
  logic [15:0] sen;
  logic [79:0] sch;
  logic [3:0] wr_slot;
  int n_errors = 0;
  int checked = 0;
  viu_vectored_irq_unit DUT (.clock(clock), .rst_b(rst_b), .watchdog_flag(fl[0]),
    .soft_request(fl[1]), .debug_rx_request(fl[2]), .debug_tx_request(fl[3]),
    .timer0_match_flag(fl[7:4]), .timer0_capture_flag(fl[11:8]), .timer1_match_flag(fl[15:12]),
    .timer1_capture_flag(fl[19:16]), .uart0_rx_line_status_flag(fl[20]),
    .uart0_tx_holding_empty_flag(fl[21]), .uart0_rx_data_avail_flag(fl[22]),
    .uart0_char_timeout_flag(fl[23]), .uart1_rx_line_status_flag(fl[24]),
    .uart1_tx_holding_empty_flag(fl[25]), .uart1_rx_data_avail_flag(fl[26]),
    .uart1_char_timeout_flag(fl[27]), .uart1_modem_status_flag(fl[28]),
    .pwm_match_flag(fl[35:29]), .pwm_capture_flag(fl[39:36]), .i2c0_request(fl[40]),
    .spi_request(fl[41]), .ssp_tx_half_empty_flag(fl[42]), .ssp_rx_half_full_flag(fl[43]),
    .ssp_rx_timeout_flag(fl[44]), .ssp_rx_overrun_flag(fl[45]), .pll_lock_request(fl[46]),
    .rtc_counter_increment_flag(fl[47]), .rtc_alarm_flag(fl[48]), .ext_pin_request(fl[52:49]),
    .adc0_request(fl[53]), .i2c1_request(fl[54]), .brownout_request(fl[55]),
    .adc1_request(fl[56]), .channel_enable(en), .fast_select(fs), .slot_enable(sen),
    .slot_channel(sch), .default_address(dflt), .slot_addr_wr_en(wr_en),
    .slot_addr_wr_slot(wr_slot), .slot_addr_wr_data(wr_data), .handler_read(hread),
    .handler_address(hadr), .handler_valid(hvalid), .fast_request_out(freq),
    .normal_request_out(nreq), .raw_status(raw), .fast_status(fst), .normal_status(nst),
    .nonvectored_status(nvs));
  viu_core_model core (.clock(clock), .rst_b(rst_b), .start(start), .done(done), .vector(vec),
    .handler_valid(hvalid), .handler_address(hadr), .handler_read(hread));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic read_expect(input logic [31:0] exp);
    int i;
    i = 0;
    @(posedge clock) start <= 1'b1;
    @(posedge clock) start <= 1'b0;
    while (done !== 1'b1 && i < 10) begin
      tick(1);
      i++;
    end
    check("read answered", {31'h0, done}, 32'h1);
    check("handler address", vec, exp);
  endtask
  task automatic check_idle();
    check("idle status", raw | fst | nst | nvs | hadr, 32'h0);
    check("idle lines", {29'h0, hvalid, freq, nreq}, 32'h0);
  endtask
  function automatic logic [56:0] mask_from(input int first);
    logic [56:0] m;
    m = 57'h1;
    for (int c = first; c < 18; c++) m |= 57'(1) << BND[c];
    return m;
  endfunction
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Tests need about 930 cycles
  initial begin
    #(40 * 20000);
    n_errors++;
    complete_run();
  end
  initial begin
    {rst_b, start, wr_en, fl, fs, sen, sch, wr_slot, wr_data} = '0;
    en = '1;
    dflt = 32'hdef0;
    tick(10);
    check_idle();
    @(posedge clock) rst_b <= 1'b1;
    // Rows: channel c, flag bits BND[c]..BND[c+1]-1, status bit c
    for (int m = 0; m < 2; m++) begin
      @(posedge clock) fs <= {32{m[0]}};
      for (int c = 0; c < 22; c++) begin
        for (int b = BND[c]; b < BND[c + 1]; b++) begin
          @(posedge clock) fl <= 57'(1) << b;
          tick(5);
          check("raw", raw, 32'(1) << c);
          check("fast", fst, m ? 32'(1) << c : 32'h0);
          check("normal", nst, m ? 32'h0 : 32'(1) << c);
          check("non-vectored", nvs, m ? 32'h0 : 32'(1) << c);
          check("requests", {30'h0, freq, nreq}, m ? 32'h2 : 32'h1);
        end
      end
      $display("test class map %0d done", m);
    end
    @(posedge clock) begin
      fs <= '0;
      en <= ~32'h40;
      fl <= (57'(1) << BND[6]) | (57'(1) << BND[7]);
    end
    tick(5);
    check("disabled", nst, 32'h80);
    $display("test disable done");
    for (int s = 0; s < 16; s++) begin
      @(posedge clock) begin
        en <= '1;
        wr_en <= 1'b1;
        wr_slot <= 4'(s);
        wr_data <= 32'(32'h1000 + 4 * s);
        sch[5 * s +: 5] <= 5'(s + 2);
      end
    end
    @(posedge clock) begin
      wr_en <= 1'b0;
      sen <= '1;
    end
    for (int s = 0; s < 17; s++) begin
      v = mask_from(s + 2);
      @(posedge clock) fl <= v;
      tick(5);
      read_expect(s < 16 ? 32'(32'h1000 + 4 * s) : dflt);
      check("non-vectored", nvs, 32'h1);
    end
    $display("test slots done");
    @(posedge clock) begin
      fs <= 32'h4;
      fl <= mask_from(2);
    end
    tick(5);
    check("fast line", {31'h0, freq}, 32'h1);
    read_expect(32'h1004);
    $display("test fast class done");
    @(posedge clock) rst_b <= 1'b0;
    tick(2);
    check_idle();
    @(posedge clock) rst_b <= 1'b1;
    tick(1);
    check("raw after reset", raw, 32'h3ffd);
    check("status after reset", fst | nst | nvs | hadr, 32'h0);
    check("lines after reset", {29'h0, hvalid, freq, nreq}, 32'h0);
    tick(5);
    read_expect(32'h0);
    $display("test reset done");
    complete_run();
  end
endmodule // test_viu_vectored_irq_unit
bind viu_vectored_irq_unit viu_checker chk (.*);
`default_nettype wire
